// file: fpc_map.svh
// register offsets, field values and timing figures of the fifo controller
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_CLK_NS 8
`define FPC_STRB_NS 40
`define FPC_REC_NS 48
`define FPC_CLR_NS 80
`define FPC_SYNC_CYC 2
`define FPC_A_CMD 5'h00
`define FPC_A_WDATA 5'h04
`define FPC_A_MODE 5'h08
`define FPC_A_RDATA 5'h0c
`define FPC_A_STATUS 5'h10
`define FPC_OP_CLR 3'h1
`define FPC_OP_WR 3'h2
`define FPC_OP_RD 3'h3
`define FPC_OP_RT 3'h4
`define FPC_RESP_OK 2'h0
`define FPC_RESP_ERR 2'h2
`define FPC_WORD_RST 9'h000
`endif

// file: fpc_pkg.sv
// types shared by the fifo controller files
package fpc_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CLR_LO = 3'b001,
    S_WR_LO = 3'b010,
    S_RD_LO = 3'b011,
    S_RT_LO = 3'b100,
    S_REC = 3'b101
  } fpc_state_t;

  typedef struct packed {
    logic clear_all_n;
    logic write_n;
    logic read_n;
    logic replay_n;
    logic chain_in_n;
    logic [8:0] in_word;
  } fpc_pin_out_t;

  typedef struct packed {
    logic [8:0] out_word;
    logic empty_indicator_n;
    logic full_indicator_n;
    logic half_full_indicator_n;
  } fpc_pin_in_t;

  typedef struct packed {
    logic not_first;
    logic expand;
  } fpc_mode_t;

  typedef struct packed {
    logic [25:0] zero;
    logic refused;
    logic cleared;
    logic busy;
    logic half_full_n;
    logic full_n;
    logic empty_n;
  } fpc_status_t;
endpackage

// file: fpc_sync.sv
// two-stage synchroniser for device pin inputs
`timescale 1ns/100ps
`default_nettype none
module fpc_sync #(
  parameter int W = 1
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: fpc_ctrl.sv
// fifo pin controller with axi4-lite command and status registers
// Summary of operation
// RL1: device stores up to 16384 nine-bit words in first-in first-out order.
// RL2: device keeps its own read and write pointers; no address supplied.
// RL3: clear low returns both device pointers to the first location.
// RL4: a clear must precede any write after power-up.
// RL5: both strobes high before clear rises and unchanged shortly after.
// RL6: half-full high after clear; flags valid once clear completes.
// RL7: write starts on strobe fall only when full is not asserted.
// RL8: written words go to sequential locations regardless of reads.
// RL9: half-full goes low past half capacity, released on read rise.
// RL10: while full, write strobe changes neither data nor pointer.
// RL11: after a read on a full buffer, full rises after a delay.
// RL12: read starts on strobe fall only when empty is not asserted.
// RL13: data outputs float once the read strobe returns high.
// RL14: last word read drives empty low and inhibits further reads.
// RL15: after a write on an empty buffer, empty rises after a delay.
// RL16: while empty, read strobe does not move the read pointer.
// RL17: shared pin marks first chain device, or is replay when single.
// RL18: chain input low selects single mode, else fed from chain.
// RL19: replay pulse low resets read pointer only.
// RL20: half-full is re-evaluated after replay.
// RL21: both strobes stay high for the whole replay pulse.
// RL22: replay only within one depth of writes, never when chained; the controller refuses only the chained case.
// RL23: full asserted when write pointer is one behind read pointer.
// RL24: empty asserted whenever read and write pointers are equal.
// RL25: when chained, half-full pin pulses the next device at last location.
// RL26: single mode pointers advance only while their flag is high.
// RL27: both device pointers wrap from last location to first.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"
module fpc_ctrl
  import fpc_pkg::*;
#(
  parameter int CLK_NS = `FPC_CLK_NS,
  parameter int STRB_NS = `FPC_STRB_NS,
  parameter int REC_NS = `FPC_REC_NS,
  parameter int CLR_NS = `FPC_CLR_NS
) (
  input wire logic aclk, // clock, 125 mhz
  input wire logic aresetn, // sync reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [4:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [4:0] araddr, // read address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output fpc_pin_out_t pin_o, // pins driven into the fifo device
  input wire fpc_pin_in_t pin_i // pins read from the fifo device
);
  function automatic logic [7:0] ns2cyc(input int ns);
    ns2cyc = 8'((ns + CLK_NS - 1) / CLK_NS);
  endfunction

  localparam logic [7:0] STRB_CYC = ns2cyc(STRB_NS) + 8'(`FPC_SYNC_CYC);
  localparam logic [7:0] REC_CYC = ns2cyc(REC_NS) + 8'(`FPC_SYNC_CYC);
  localparam logic [7:0] CLR_CYC = ns2cyc(CLR_NS);

  fpc_state_t state_q;
  fpc_pin_out_t pin_q;
  fpc_pin_in_t pin_s;
  fpc_mode_t mode_q;
  logic [7:0] cnt_q;
  logic [8:0] wword_q, rword_q;
  logic cleared_q, refused_q;
  logic aw_have_q, w_have_q, bvalid_q, awready_q, wready_q;
  logic arready_q, rvalid_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, cmd_fire, op_ok, mapped_w;
  logic [2:0] op;
  fpc_status_t status;

  fpc_sync #(.W($bits(fpc_pin_in_t))) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pin_i),
    .q(pin_s)
  );

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pin_o = pin_q;

  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign mapped_w = (awaddr_q == `FPC_A_CMD) | (awaddr_q == `FPC_A_WDATA) |
                    (awaddr_q == `FPC_A_MODE);
  assign cmd_fire = wr_fire & (awaddr_q == `FPC_A_CMD) & wstrb_ok();
  assign op = wdata_q[2:0];

  function automatic logic wstrb_ok();
    wstrb_ok = 1'b1;
  endfunction

  // command is accepted only when the sequencer is free and flags allow it
  always_comb begin
    op_ok = 1'b0;
    if (state_q == S_IDLE) begin
      case (op)
        `FPC_OP_CLR: op_ok = 1'b1;
        // RL4 RL7 write gated by clear and full
        `FPC_OP_WR: op_ok = cleared_q & pin_s.full_indicator_n;
        // RL12 read gated by empty
        `FPC_OP_RD: op_ok = pin_s.empty_indicator_n;
        // RL22 no replay when chained
        `FPC_OP_RT: op_ok = ~mode_q.expand;
        default: op_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    status = '0;
    status.empty_n = pin_s.empty_indicator_n;
    status.full_n = pin_s.full_indicator_n;
    status.half_full_n = pin_s.half_full_indicator_n;
    status.busy = (state_q != S_IDLE);
    status.cleared = cleared_q;
    status.refused = refused_q;
  end

  // axi write channels, address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `FPC_RESP_OK;
      awaddr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= wdata;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped_w ? `FPC_RESP_OK : `FPC_RESP_ERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // software registers: outgoing word and chain mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wword_q <= `FPC_WORD_RST;
      mode_q <= '0;
    end else if (wr_fire) begin
      if (awaddr_q == `FPC_A_WDATA && wstrb_ok())
        wword_q <= wdata_q[8:0];
      if (awaddr_q == `FPC_A_MODE)
        mode_q <= fpc_mode_t'(wdata_q[1:0]);
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `FPC_RESP_OK;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `FPC_RESP_OK;
      case (araddr)
        `FPC_A_WDATA: rdata_q <= {23'h000000, wword_q};
        `FPC_A_MODE: rdata_q <= {30'h00000000, mode_q};
        `FPC_A_RDATA: rdata_q <= {23'h000000, rword_q};
        `FPC_A_STATUS: rdata_q <= status;
        `FPC_A_CMD: rdata_q <= '0;
        default: begin
          rdata_q <= '0;
          rresp_q <= `FPC_RESP_ERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // refused command flag; a new refusal wins over the clearing accept
  always_ff @(posedge aclk) begin
    if (!aresetn)
      refused_q <= 1'b0;
    else if (cmd_fire && !op_ok)
      refused_q <= 1'b1;
    else if (cmd_fire)
      refused_q <= 1'b0;
  end

  // strobe sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      cleared_q <= 1'b0;
      rword_q <= `FPC_WORD_RST;
      pin_q <= '{clear_all_n: 1'b1, write_n: 1'b1, read_n: 1'b1,
                 replay_n: 1'b1, chain_in_n: 1'b0, in_word: `FPC_WORD_RST};
    end else begin
      // RL17 RL18 shared pin and chain input follow the mode
      pin_q.chain_in_n <= mode_q.expand;
      case (state_q)
        S_IDLE: begin
          pin_q.replay_n <= mode_q.expand ? mode_q.not_first : 1'b1;
          if (cmd_fire && op_ok) begin
            case (op)
              `FPC_OP_CLR: begin
                state_q <= S_CLR_LO;
                cnt_q <= CLR_CYC;
                pin_q.clear_all_n <= 1'b0;
              end
              `FPC_OP_WR: begin
                state_q <= S_WR_LO;
                cnt_q <= STRB_CYC;
                pin_q.in_word <= wword_q;
                pin_q.write_n <= 1'b0;
              end
              `FPC_OP_RD: begin
                state_q <= S_RD_LO;
                cnt_q <= STRB_CYC;
                pin_q.read_n <= 1'b0;
              end
              default: begin
                // RL21 RL19 replay with both strobes held high
                state_q <= S_RT_LO;
                cnt_q <= STRB_CYC;
                pin_q.replay_n <= 1'b0;
              end
            endcase
          end
        end
        S_CLR_LO, S_WR_LO, S_RD_LO, S_RT_LO: begin
          if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            // RL5 strobes stay high across the clear rise and recovery
            if (state_q == S_CLR_LO)
              cleared_q <= 1'b1;
            // RL13 sample data before the read strobe rises
            if (state_q == S_RD_LO)
              rword_q <= pin_s.out_word;
            pin_q.clear_all_n <= 1'b1;
            pin_q.write_n <= 1'b1;
            pin_q.read_n <= 1'b1;
            pin_q.replay_n <= mode_q.expand ? mode_q.not_first : 1'b1;
            state_q <= S_REC;
            cnt_q <= REC_CYC;
          end
        end
        S_REC: begin
          // RL11 RL15 RL6 wait out flag delay before the next command
          if (cnt_q > 8'h01)
            cnt_q <= cnt_q - 8'h01;
          else
            state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // RL4 no write before a clear
  a_write_after_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pin_q.write_n) |-> cleared_q) else $error("write before clear"); // RL4
  // RL5 strobes high around clear release
  a_strobes_at_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pin_q.clear_all_n) |-> $past(pin_q.write_n) && $past(pin_q.read_n)
    ##0 (pin_q.write_n && pin_q.read_n)[*3])
    else $error("strobe moved near clear release"); // RL5
  // RL21 strobes high while replaying
  a_strobes_replay: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == S_RT_LO) |-> !pin_q.replay_n && pin_q.write_n && pin_q.read_n)
    else $error("strobe low during replay"); // RL21
  // RL22 replay never when chained
  a_replay_single: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pin_q.replay_n) && (state_q == S_RT_LO) |-> !mode_q.expand)
    else $error("replay in chained mode"); // RL22
  // RL7 RL10 write only when not full
  a_write_not_full: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pin_q.write_n) |-> $past(pin_s.full_indicator_n))
    else $error("write on full device"); // RL10
  // RL12 RL16 read only when not empty
  a_read_not_empty: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pin_q.read_n) |-> $past(pin_s.empty_indicator_n))
    else $error("read on empty device"); // RL16
  c_clear: cover property (@(posedge aclk) $rose(pin_q.clear_all_n));
  c_write: cover property (@(posedge aclk) $rose(pin_q.write_n));
  c_read: cover property (@(posedge aclk) $rose(pin_q.read_n));
  c_replay: cover property (@(posedge aclk) state_q == S_RT_LO);
endmodule
`default_nettype wire

// file: fpc_fifo_model.sv
// behavioural fifo device that answers the controller pins
`timescale 1ns/100ps
`default_nettype none
module fpc_fifo_model
  import fpc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int FLAG_NS = 16,
  parameter int HOLD_NS = 8
) (
  input wire fpc_pin_out_t pins, // pins from the controller
  output var fpc_pin_in_t flags, // pins back to the controller
  output var int viol // count of pin sequencing faults
);
  logic [8:0] mem [DEPTH];
  logic [8:0] dq = 9'h000;
  int wp, rp, cnt;
  bit clr, wr_on, rd_on, half_n = 1'b1, xo_n = 1'b1;
  realtime t_clr;
  initial viol = 0;
  // flag outputs, chain pulse replaces half-full
  assign #(FLAG_NS) flags = {dq, cnt != 0, cnt != DEPTH,
    pins.chain_in_n ? xo_n : half_n};
  function automatic bit bad_ctx();
    return !pins.clear_all_n || (!pins.replay_n && !pins.chain_in_n) ||
      $realtime - t_clr < HOLD_NS;
  endfunction
  always @(pins.clear_all_n) begin
    if (!pins.clear_all_n) begin
      {wp, rp, cnt} = '0;
      {half_n, clr, wr_on, rd_on} = 4'b1100;
    end else begin
      t_clr = $realtime;
      if (!pins.write_n || !pins.read_n) viol++;
    end
  end
  always @(negedge pins.write_n) begin
    if (bad_ctx() || !clr) viol++;
    wr_on = clr && cnt != DEPTH;
    if (wr_on && cnt == DEPTH / 2) half_n = 1'b0;
    // pulse to the next device while writing the last location
    xo_n = !(wr_on && pins.chain_in_n && wp == DEPTH - 1);
  end
  always @(posedge pins.write_n) begin
    if (wr_on) begin
      mem[wp] = pins.in_word;
      wp = (wp + 1) % DEPTH;
      cnt++;
    end
    wr_on = 1'b0;
    xo_n = 1'b1;
  end
  always @(negedge pins.read_n) begin
    if (bad_ctx()) viol++;
    rd_on = cnt != 0;
    if (rd_on) dq = mem[rp];
  end
  always @(posedge pins.read_n) begin
    if (rd_on) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      if (cnt <= DEPTH / 2) half_n = 1'b1;
    end
    rd_on = 1'b0;
    dq = ~dq;
  end
  always @(negedge pins.replay_n) begin
    if (!pins.chain_in_n) begin
      if (!pins.write_n || !pins.read_n) viol++;
      rp = 0;
      cnt = wp;
      half_n = !(cnt > DEPTH / 2);
    end
  end
endmodule
`default_nettype wire

// file: tb_fpc_ctrl.sv
// testbench of the fifo pin controller with a fifo device model
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"
module tb_fpc_ctrl
  import fpc_pkg::*;
();
  localparam int DEPTH = 16;
  localparam int LIMIT = 20000;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  fpc_pin_out_t pin_o;
  fpc_pin_in_t pin_i;
  int viol, seed, error_cnt = 0, checks = 0, cyc = 0;
  int modes[3] = '{3, 1, 0};
  logic [1:0] pexp[3] = '{2'b11, 2'b01, 2'b10};
  logic [8:0] fq[$];
  logic [8:0] hist[$];
  bit cleared = 1'b0;
  fpc_ctrl i_fpc_ctrl (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pin_o(pin_o), .pin_i(pin_i));
  fpc_fifo_model #(.DEPTH(DEPTH)) i_fpc_fifo_model (.pins(pin_o),
    .flags(pin_i), .viol(viol));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_resp(input string what, input logic [1:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    bit got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
  endtask
  function automatic logic [31:0] exp_st(input bit refuse);
    return {26'h0, refuse, cleared, 1'b0, fq.size() <= DEPTH / 2,
      fq.size() < DEPTH, fq.size() > 0};
  endfunction
  function automatic logic [8:0] rnd();
    return 9'($random(seed));
  endfunction
  // issue a command, wait for idle, compare status with the reference
  task automatic cmd(input logic [2:0] op, input bit refuse);
    logic [1:0] r;
    logic [31:0] st;
    int n;
    n = 0;
    axi_wr(`FPC_A_CMD, 32'(op), r);
    chk_resp("cmd resp", `FPC_RESP_OK, r);
    do begin
      axi_rd(`FPC_A_STATUS, st, r);
      n++;
    end while (st[3] !== 1'b0 && n < 50);
    if (!refuse) chk("busy seen", 32'h1, 32'(n > 1));
    chk("status", exp_st(refuse), st);
  endtask
  task automatic push(input logic [8:0] v);
    logic [1:0] r;
    bit refuse;
    refuse = !cleared || fq.size() == DEPTH;
    axi_wr(`FPC_A_WDATA, 32'(v), r);
    if (!refuse) begin
      fq.push_back(v);
      hist.push_back(v);
    end
    cmd(`FPC_OP_WR, refuse);
  endtask
  task automatic pop();
    logic [1:0] r;
    logic [31:0] d;
    logic [8:0] e;
    bit refuse;
    refuse = fq.size() == 0;
    if (!refuse) e = fq.pop_front();
    cmd(`FPC_OP_RD, refuse);
    if (!refuse) begin
      axi_rd(`FPC_A_RDATA, d, r);
      chk("read word", 32'(e), d);
    end
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    seed = 41321;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pins idle", 32'(14'h3c00), 32'(pin_o));
    // pin synchroniser needs two edges before status shows real flags
    repeat (2) @(posedge aclk);
    axi_rd(`FPC_A_STATUS, d, r);
    chk("status at reset", exp_st(1'b0), d);
    push(rnd());
    axi_wr(5'h14, 32'h0, r);
    chk_resp("unmapped write", `FPC_RESP_ERR, r);
    axi_rd(5'h1c, d, r);
    chk_resp("unmapped read", `FPC_RESP_ERR, r);
    foreach (modes[i]) begin
      axi_wr(`FPC_A_MODE, modes[i], r);
      axi_rd(`FPC_A_MODE, d, r);
      chk("mode", modes[i], d);
      chk("mode pins", 32'(pexp[i]), {pin_o.replay_n, pin_o.chain_in_n});
      if (i == 1) cmd(`FPC_OP_RT, 1'b1);
    end
    cmd(3'h7, 1'b1);
    cleared = 1'b1;
    cmd(`FPC_OP_CLR, 1'b0);
    for (int i = 0; i <= DEPTH; i++) push(rnd());
    pop();
    push(rnd());
    for (int i = 0; i <= DEPTH; i++) pop();
    axi_wr(`FPC_A_CMD, 32'(`FPC_OP_CLR), r);
    cmd(`FPC_OP_CLR, 1'b1);
    hist.delete();
    repeat (10) push(rnd());
    repeat (4) pop();
    fq = hist;
    cmd(`FPC_OP_RT, 1'b0);
    repeat (10) pop();
    chk("pin faults", 32'h0, viol);
    complete_run();
  end
endmodule
`default_nettype wire
